// [logic/lcs_pkg.sv]
// constants, register map and per-device tables of the logical device config space
package lcs_pkg;

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int NUM_DEV = 15;
    localparam int VEND_CNT = 15;
    localparam logic [7:0] LDN_MAX = 8'h0E;
    localparam int DEV_WAKE = 4;

    // ------------------------------------------------------------
    // configuration port and index map
    // ------------------------------------------------------------
    localparam logic [15:0] CFG_BASE_LOW = 16'h002E;
    localparam logic [15:0] CFG_BASE_HIGH = 16'h004E;
    localparam logic [15:0] CFG_DATA_OFS = 16'h0001;
    localparam logic [7:0] IDX_LDN = 8'h07;
    localparam logic [7:0] IDX_GCR1 = 8'h21;
    localparam logic [7:0] IDX_GCR3 = 8'h23;
    localparam logic [7:0] IDX_PSEL = 8'h24;
    localparam logic [7:0] IDX_ACT = 8'h30;
    localparam logic [7:0] IDX_B0H = 8'h60;
    localparam logic [7:0] IDX_B0L = 8'h61;
    localparam logic [7:0] IDX_B1H = 8'h62;
    localparam logic [7:0] IDX_B1L = 8'h63;
    localparam logic [7:0] IDX_IRQ = 8'h70;
    localparam logic [7:0] IDX_IRQT = 8'h71;
    localparam logic [7:0] IDX_DMA0 = 8'h74;
    localparam logic [7:0] IDX_DMA1 = 8'h75;
    localparam logic [7:0] IDX_VEND_LO = 8'hF0;
    localparam logic [7:0] IDX_VEND_HI = 8'hFE;

    // ------------------------------------------------------------
    // field positions and values
    // ------------------------------------------------------------
    localparam int GCR1_SWRST = 1;
    localparam int GCR1_LOCK = 7;
    localparam logic [7:0] GCR1_KEEP_MASK = 8'h80;
    localparam logic [7:0] GCR3_DEFAULT = 8'h00;
    localparam logic [7:0] PSEL_DEFAULT = 8'h00;
    localparam logic [2:0] DMA_NONE = 3'h4;
    localparam logic [7:0] DMA_NONE_READ = 8'h04;
    localparam logic [15:0] LEGACY_ADDR_MASK = 16'h07FF;
    localparam logic [15:0] PP_LIMIT = 16'h03F8;

    // ------------------------------------------------------------
    // per-device tables, index is the logical device number
    // ------------------------------------------------------------
    localparam logic [2:0] DEV_ALIGN [NUM_DEV] = '{3'h3, 3'h3, 3'h3, 3'h3, 3'h4, 3'h0, 3'h0,
        3'h4, 3'h3, 3'h4, 3'h1, 3'h3, 3'h1, 3'h5, 3'h4};
    localparam logic [15:0] DEV_EXTRA_MASK [NUM_DEV] = '{16'h0000, 16'h0400, 16'h0000,
        16'h0000, 16'h0000, 16'h0000, 16'h0004, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
        16'h0000, 16'h0000, 16'h0000, 16'h0000};
    localparam logic [15:0] DEV_DEF_BASE0 [NUM_DEV] = '{16'h03F0, 16'h0378, 16'h02F8,
        16'h03F8, 16'h0000, 16'h0000, 16'h0060, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
        16'h0000, 16'h0000, 16'h0000, 16'h0000};
    localparam logic [15:0] DEV_DEF_BASE1 [NUM_DEV] = '{16'h0000, 16'h0000, 16'h0000,
        16'h0000, 16'h0000, 16'h0000, 16'h0064, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
        16'h0000, 16'h0000, 16'h0000, 16'h0000};
    localparam logic [3:0] DEV_DEF_IRQ [NUM_DEV] = '{4'h6, 4'h7, 4'h3, 4'h4, 4'h0, 4'hC,
        4'h1, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0};
    localparam logic [2:0] DEV_DEF_DMA0 [NUM_DEV] = '{3'h2, 3'h4, 3'h4, 3'h4, 3'h4, 3'h4,
        3'h4, 3'h4, 3'h4, 3'h4, 3'h4, 3'h4, 3'h4, 3'h4, 3'h4};
    localparam logic [NUM_DEV-1:0] DEV_HAS_BASE1 = 15'h0044;
    localparam logic [NUM_DEV-1:0] DEV_HAS_DMA0 = 15'h0007;
    localparam logic [NUM_DEV-1:0] DEV_HAS_DMA1 = 15'h0004;
    localparam logic [NUM_DEV-1:0] DEV_LEGACY = 15'h006D;
    localparam logic [NUM_DEV-1:0] DEV_DEF_ACTIVE = 15'h0060;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [15:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } lcs_io_req_t;

    typedef struct packed {
        logic activate;
        logic [15:0] base0;
        logic [15:0] base1;
        logic irq_wake;
        logic [3:0] irq_num;
        logic irq_level;
        logic irq_high;
        logic [2:0] dma0;
        logic [2:0] dma1;
    } lcs_dev_cfg_t;

    function automatic lcs_dev_cfg_t lcs_dev_default(input int d);
        lcs_dev_cfg_t c;
        c.activate = DEV_DEF_ACTIVE[d];
        c.base0 = DEV_DEF_BASE0[d];
        c.base1 = DEV_DEF_BASE1[d];
        c.irq_wake = 1'b0;
        c.irq_num = DEV_DEF_IRQ[d];
        c.irq_level = 1'b0;
        c.irq_high = 1'b0;
        c.dma0 = DEV_DEF_DMA0[d];
        c.dma1 = DMA_NONE;
        return c;
    endfunction

    function automatic logic [15:0] lcs_align_mask(input logic [2:0] a);
        return ~(16'hFFFF << a);
    endfunction

endpackage

// [logic/lcs_config_space.sv]
// per-logical-device configuration register space behind the index/data port
`timescale 1ns/1ps

// Operation
// R1 - first dma select low three bits pick channel 0-3, 4 means none
// R2 - second dma select encoded the same way as the first
// R3 - indexes f0h-feh hold function-specific settings per device
// R4 - activate bit 0 enables block; inactive block decodes nothing, resources detached
// R5 - primary 16-bit base at 60-61h, optional secondary base at 62-63h
// R6 - software reset bit resets devices and globals, locked bits keep value
// R7 - bus reset resets all devices except wake-up controller and non-backup globals
// R8 - backup power-up reset clears all backup-retained registers
// R9 - standby power-up reset initialises wake-up controller, backup registers untouched
// R10 - config port decodes at 2eh or 4eh chosen by strap after hardware reset
// R11 - after hardware reset only keyboard/mouse controller is active
// R12 - multiplexed pins default gpio input with pull-up, except backup and gcr3 pins
// R13 - after reset legacy devices get legacy resources, others base zero
// R14 - all 16 address bits compared for config port and device ranges
// R15 - low base bits below range size forced zero, read-only
// R16 - floppy, serial and keyboard bases have address bits 11-15 forced zero
// R17 - parallel port base accepts only addresses up to 3f8h
// R18 - nonlegacy device bases programmable across the full 16-bit space
// R19 - keyboard uses address bit 2, parallel port bit 10, for register select
// R20 - unimplemented registers ignore writes, read zero, dma indexes read 04h
// R21 - logical device number selects which device's registers 30h and up address
// R22 - host read-modify-writes and checks activation before using a range
module lcs_config_space
    import lcs_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic lpc_reset,
    input wire logic vsb_por,
    input wire logic config_base_strap,
    input wire lcs_io_req_t io_req,
    output logic [7:0] io_rdata,
    output logic io_rd_valid,
    output logic [NUM_DEV-1:0] dev_active,
    output logic [NUM_DEV-1:0] dev_hit,
    output logic [4:0] dev_hit_offset,
    output logic dev_hit_sel,
    output logic [NUM_DEV-1:0][3:0] dev_irq_num,
    output logic [NUM_DEV-1:0] dev_irq_level,
    output logic [NUM_DEV-1:0] dev_irq_high,
    output logic [NUM_DEV-1:0] dev_irq_wake,
    output logic [NUM_DEV-1:0][2:0] dev_dma_first,
    output logic [NUM_DEV-1:0][2:0] dev_dma_second,
    output logic [7:0] global_config_reg_three,
    output logic [7:0] pin_select_backup,
    output logic pin_lock
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    lcs_dev_cfg_t dev_reg [NUM_DEV];
    lcs_dev_cfg_t dev_next [NUM_DEV];
    logic [7:0] vend_reg [NUM_DEV][VEND_CNT];
    logic [7:0] vend_next [NUM_DEV][VEND_CNT];
    logic [7:0] idx_reg, idx_next;
    logic [7:0] ldn_reg, ldn_next;
    logic [7:0] gcr1_reg, gcr1_next;
    logic [7:0] gcr3_reg, gcr3_next;
    logic [7:0] psel_reg, psel_next;
    logic sw_rst_reg, sw_rst_next;
    logic strap_reg, strap_next;
    logic first_reg;
    logic [7:0] rdata_reg, rdata_next;
    logic rvalid_reg, rvalid_next;
    logic [NUM_DEV-1:0] hit_reg, hit_next;
    logic [NUM_DEV-1:0] sel_bits;
    logic [4:0] ofs_reg;
    logic sel_reg;
    logic [NUM_DEV-1:0] act_reg, act_next;
    logic [NUM_DEV-1:0][3:0] irqn_reg, irqn_next;
    logic [NUM_DEV-1:0] irql_reg, irql_next, irqh_reg, irqh_next, irqw_reg, irqw_next;
    logic [NUM_DEV-1:0][2:0] dma0_reg, dma0_next, dma1_reg, dma1_next;

    logic [15:0] cfg_base;
    logic hit_index, hit_data, ldn_ok;
    logic [3:0] cur;
    lcs_dev_cfg_t cd;
    logic [15:0] cand;
    logic [3:0] vofs;

    // ------------------------------------------------------------
    // base address write filter
    // ------------------------------------------------------------
    function automatic logic [15:0] fix_base(input int d, input logic [15:0] v,
                                             input logic [15:0] old);
        logic [15:0] r;
        r = v & ~lcs_align_mask(DEV_ALIGN[d]); // R15
        if (DEV_LEGACY[d]) begin
            r = r & LEGACY_ADDR_MASK; // R16
        end
        if (d == 1 && r > PP_LIMIT) begin
            r = old; // R17
        end
        return r; // R18
    endfunction

    // ------------------------------------------------------------
    // configuration access and resets
    // ------------------------------------------------------------
    always_comb begin
        dev_next = dev_reg;
        vend_next = vend_reg;
        idx_next = idx_reg;
        ldn_next = ldn_reg;
        gcr1_next = gcr1_reg;
        gcr3_next = gcr3_reg;
        psel_next = psel_reg;
        sw_rst_next = 1'b0;
        rdata_next = 8'h00;
        rvalid_next = 1'b0;
        strap_next = strap_reg;
        cand = 16'h0000;
        // strap is caught by a clock edge, never by the async reset itself
        if (first_reg || lpc_reset) begin
            strap_next = config_base_strap; // R10
        end
        cfg_base = strap_reg ? CFG_BASE_HIGH : CFG_BASE_LOW; // R10
        hit_index = io_req.addr == cfg_base; // R14
        hit_data = io_req.addr == 16'(cfg_base + CFG_DATA_OFS); // R14
        ldn_ok = ldn_reg <= LDN_MAX; // R21
        cur = ldn_ok ? ldn_reg[3:0] : 4'h0;
        cd = dev_reg[cur];
        vofs = 4'(idx_reg - IDX_VEND_LO);

        // reads
        if (io_req.rd && (hit_index || hit_data)) begin
            rvalid_next = 1'b1;
            if (hit_index) begin
                rdata_next = idx_reg;
            end else if (idx_reg == IDX_LDN) begin
                rdata_next = ldn_reg;
            end else if (idx_reg == IDX_GCR1) begin
                rdata_next = gcr1_reg;
            end else if (idx_reg == IDX_GCR3) begin
                rdata_next = gcr3_reg;
            end else if (idx_reg == IDX_PSEL) begin
                rdata_next = psel_reg;
            end else if (idx_reg == IDX_DMA0) begin
                rdata_next = (ldn_ok && DEV_HAS_DMA0[cur]) ? {5'h00, cd.dma0} : DMA_NONE_READ; // R20
            end else if (idx_reg == IDX_DMA1) begin
                rdata_next = (ldn_ok && DEV_HAS_DMA1[cur]) ? {5'h00, cd.dma1} : DMA_NONE_READ; // R20
            end else if (ldn_ok) begin
                unique case (idx_reg)
                    IDX_ACT: rdata_next = {7'h00, cd.activate};
                    IDX_B0H: rdata_next = cd.base0[15:8];
                    IDX_B0L: rdata_next = cd.base0[7:0];
                    IDX_B1H: rdata_next = DEV_HAS_BASE1[cur] ? cd.base1[15:8] : 8'h00;
                    IDX_B1L: rdata_next = DEV_HAS_BASE1[cur] ? cd.base1[7:0] : 8'h00;
                    IDX_IRQ: rdata_next = {3'h0, cd.irq_wake, cd.irq_num};
                    IDX_IRQT: rdata_next = {6'h00, cd.irq_high, cd.irq_level};
                    default: begin
                        if (idx_reg >= IDX_VEND_LO && idx_reg <= IDX_VEND_HI) begin
                            rdata_next = vend_reg[cur][vofs]; // R3
                        end
                    end
                endcase
            end
        end

        // writes
        if (io_req.wr && hit_index) begin
            idx_next = io_req.wdata;
        end
        if (io_req.wr && hit_data) begin
            if (idx_reg == IDX_LDN) begin
                ldn_next = io_req.wdata; // R21
            end else if (idx_reg == IDX_GCR1) begin
                sw_rst_next = io_req.wdata[GCR1_SWRST]; // R6
                gcr1_next = io_req.wdata;
                gcr1_next[GCR1_SWRST] = 1'b0;
                gcr1_next[GCR1_LOCK] = gcr1_reg[GCR1_LOCK] | io_req.wdata[GCR1_LOCK];
            end else if (idx_reg == IDX_GCR3 && !gcr1_reg[GCR1_LOCK]) begin
                gcr3_next = io_req.wdata;
            end else if (idx_reg == IDX_PSEL && !gcr1_reg[GCR1_LOCK]) begin
                psel_next = io_req.wdata;
            end else if (ldn_ok) begin
                unique case (idx_reg)
                    IDX_ACT: dev_next[cur].activate = io_req.wdata[0]; // R4
                    IDX_B0H: begin
                        cand = {io_req.wdata, cd.base0[7:0]};
                        dev_next[cur].base0 = fix_base(int'(cur), cand, cd.base0); // R5
                    end
                    IDX_B0L: begin
                        cand = {cd.base0[15:8], io_req.wdata};
                        dev_next[cur].base0 = fix_base(int'(cur), cand, cd.base0); // R5
                    end
                    IDX_B1H: begin
                        cand = {io_req.wdata, cd.base1[7:0]};
                        if (DEV_HAS_BASE1[cur]) begin
                            dev_next[cur].base1 = fix_base(int'(cur), cand, cd.base1); // R5
                        end
                    end
                    IDX_B1L: begin
                        cand = {cd.base1[15:8], io_req.wdata};
                        if (DEV_HAS_BASE1[cur]) begin
                            dev_next[cur].base1 = fix_base(int'(cur), cand, cd.base1); // R5
                        end
                    end
                    IDX_IRQ: begin
                        dev_next[cur].irq_wake = io_req.wdata[4];
                        dev_next[cur].irq_num = io_req.wdata[3:0];
                    end
                    IDX_IRQT: begin
                        dev_next[cur].irq_level = io_req.wdata[0];
                        dev_next[cur].irq_high = io_req.wdata[1];
                    end
                    IDX_DMA0: begin
                        if (DEV_HAS_DMA0[cur]) begin
                            dev_next[cur].dma0 = io_req.wdata[2:0]; // R1
                        end
                    end
                    IDX_DMA1: begin
                        if (DEV_HAS_DMA1[cur]) begin
                            dev_next[cur].dma1 = io_req.wdata[2:0]; // R2
                        end
                    end
                    default: begin
                        if (idx_reg >= IDX_VEND_LO && idx_reg <= IDX_VEND_HI) begin
                            vend_next[cur][vofs] = io_req.wdata; // R3
                        end
                    end
                endcase
            end
        end

        // resets override same-cycle writes to the registers they reset; reads are still answered
        if (sw_rst_reg) begin
            for (int d = 0; d < NUM_DEV; d++) begin
                dev_next[d] = lcs_dev_default(d); // R6 R13
                for (int v = 0; v < VEND_CNT; v++) begin
                    vend_next[d][v] = 8'h00;
                end
            end
            ldn_next = 8'h00;
            idx_next = 8'h00;
            gcr1_next = gcr1_next & GCR1_KEEP_MASK; // R6
            if (!gcr1_reg[GCR1_LOCK]) begin
                gcr3_next = GCR3_DEFAULT; // R6
            end
        end
        if (lpc_reset) begin
            for (int d = 0; d < NUM_DEV; d++) begin
                if (d != DEV_WAKE) begin
                    dev_next[d] = lcs_dev_default(d); // R7 R11 R13
                    for (int v = 0; v < VEND_CNT; v++) begin
                        vend_next[d][v] = 8'h00;
                    end
                end
            end
            ldn_next = 8'h00;
            idx_next = 8'h00;
            gcr1_next = 8'h00; // R7
            gcr3_next = GCR3_DEFAULT; // R12
            sw_rst_next = 1'b0;
        end
        if (vsb_por) begin
            dev_next[DEV_WAKE] = lcs_dev_default(DEV_WAKE); // R9
            for (int v = 0; v < VEND_CNT; v++) begin
                vend_next[DEV_WAKE][v] = 8'h00; // R9
            end
        end
    end

    // ------------------------------------------------------------
    // per-device decode and resource attach
    // ------------------------------------------------------------
    for (genvar g = 0; g < NUM_DEV; g++) begin : g_dev
        logic [15:0] cmp_mask;
        logic h0, h1, on;
        always_comb begin
            cmp_mask = ~(lcs_align_mask(DEV_ALIGN[g]) | DEV_EXTRA_MASK[g]); // R15 R19
            on = dev_reg[g].activate;
            h0 = dev_reg[g].base0 != 16'h0000 &&
                 (io_req.addr & cmp_mask) == (dev_reg[g].base0 & cmp_mask); // R14
            h1 = DEV_HAS_BASE1[g] && dev_reg[g].base1 != 16'h0000 &&
                 (io_req.addr & cmp_mask) == (dev_reg[g].base1 & cmp_mask); // R14
            hit_next[g] = on && (io_req.rd || io_req.wr) && (h0 || h1); // R4
            sel_bits[g] = hit_next[g] && |(io_req.addr & DEV_EXTRA_MASK[g]); // R19
            act_next[g] = on;
            irqn_next[g] = on ? dev_reg[g].irq_num : 4'h0; // R4
            irql_next[g] = on & dev_reg[g].irq_level;
            irqh_next[g] = on & dev_reg[g].irq_high;
            irqw_next[g] = on & dev_reg[g].irq_wake;
            dma0_next[g] = on ? dev_reg[g].dma0 : DMA_NONE; // R1 R4
            dma1_next[g] = on ? dev_reg[g].dma1 : DMA_NONE; // R2 R4
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            for (int d = 0; d < NUM_DEV; d++) begin
                dev_reg[d] <= lcs_dev_default(d); // R8
                for (int v = 0; v < VEND_CNT; v++) begin
                    vend_reg[d][v] <= 8'h00;
                end
            end
            idx_reg <= 8'h00;
            ldn_reg <= 8'h00;
            gcr1_reg <= 8'h00;
            gcr3_reg <= GCR3_DEFAULT;
            psel_reg <= PSEL_DEFAULT; // R8 R12
            sw_rst_reg <= 1'b0;
            strap_reg <= 1'b0;
            first_reg <= 1'b1;
            rdata_reg <= 8'h00;
            rvalid_reg <= 1'b0;
            hit_reg <= '0;
            ofs_reg <= 5'h00;
            sel_reg <= 1'b0;
            act_reg <= '0;
            irqn_reg <= '0;
            irql_reg <= '0;
            irqh_reg <= '0;
            irqw_reg <= '0;
            dma0_reg <= {NUM_DEV{DMA_NONE}};
            dma1_reg <= {NUM_DEV{DMA_NONE}};
        end else begin
            dev_reg <= dev_next;
            vend_reg <= vend_next;
            idx_reg <= idx_next;
            ldn_reg <= ldn_next;
            gcr1_reg <= gcr1_next;
            gcr3_reg <= gcr3_next;
            psel_reg <= psel_next;
            sw_rst_reg <= sw_rst_next;
            strap_reg <= strap_next;
            first_reg <= 1'b0;
            rdata_reg <= rdata_next;
            rvalid_reg <= rvalid_next;
            hit_reg <= hit_next;
            ofs_reg <= io_req.addr[4:0];
            sel_reg <= |sel_bits;
            act_reg <= act_next;
            irqn_reg <= irqn_next;
            irql_reg <= irql_next;
            irqh_reg <= irqh_next;
            irqw_reg <= irqw_next;
            dma0_reg <= dma0_next;
            dma1_reg <= dma1_next;
        end
    end

    assign io_rdata = rdata_reg;
    assign io_rd_valid = rvalid_reg;
    assign dev_active = act_reg;
    assign dev_hit = hit_reg;
    assign dev_hit_offset = ofs_reg;
    assign dev_hit_sel = sel_reg;
    assign dev_irq_num = irqn_reg;
    assign dev_irq_level = irql_reg;
    assign dev_irq_high = irqh_reg;
    assign dev_irq_wake = irqw_reg;
    assign dev_dma_first = dma0_reg;
    assign dev_dma_second = dma1_reg;
    assign global_config_reg_three = gcr3_reg;
    assign pin_select_backup = psel_reg;
    assign pin_lock = gcr1_reg[GCR1_LOCK];

endmodule

// [sim/lcs_config_space_sva.sv]
// port assertions for the logical device config space
`timescale 1ns/1ps
module lcs_config_space_sva
    import lcs_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire lcs_io_req_t io_req,
    input wire logic io_rd_valid,
    input wire logic [NUM_DEV-1:0] dev_active,
    input wire logic [NUM_DEV-1:0] dev_hit,
    input wire logic dev_hit_sel,
    input wire logic [NUM_DEV-1:0][2:0] dev_dma_first,
    input wire logic [NUM_DEV-1:0][2:0] dev_dma_second
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence s_far_rd;
        io_req.rd && io_req.addr[15:7] != 9'h000;
    endsequence
    a_rd_full_decode: assert property (s_far_rd |=> !io_rd_valid)
        else $error("read answered outside the config port");
    a_rd_needs_req: assert property (io_rd_valid |-> $past(io_req.rd))
        else $error("read data without a read");
    a_dma_code_range: assert property (dev_dma_first[0] <= 3'h4)
        else $error("reserved dma code on first select");
    a_dma_second_none: assert property (dev_dma_second[0] == DMA_NONE)
        else $error("second dma shown on a device without one");
    a_inactive_no_dma: assert property (!dev_active[0] |-> dev_dma_first[0] == DMA_NONE)
        else $error("inactive device keeps its dma channel");
    a_hit_needs_active: assert property ((dev_hit & ~dev_active) == '0)
        else $error("hit on an inactive device");
    a_floppy_low_range: assert property (dev_hit[0] |-> $past(io_req.addr[15:11]) == 5'h00)
        else $error("floppy hit above the low range");
    a_pp_limit_range: assert property (dev_hit[1] |-> $past(io_req.addr) <= 16'h07FF)
        else $error("parallel port hit above its limit");
    a_kbd_sel_bit: assert property (dev_hit[6] |-> dev_hit_sel == $past(io_req.addr[2]))
        else $error("keyboard select bit wrong");
endmodule
bind lcs_config_space lcs_config_space_sva i_sva (.clk_sys(clk_sys), .rst(rst), .io_req(io_req),
    .io_rd_valid(io_rd_valid), .dev_active(dev_active), .dev_hit(dev_hit),
    .dev_hit_sel(dev_hit_sel), .dev_dma_first(dev_dma_first), .dev_dma_second(dev_dma_second));

// [sim/lcs_host_model.sv]
// host model driving the configuration index/data port
`timescale 1ns/1ps
module lcs_host_model
    import lcs_pkg::*;
(
    input wire logic clk_sys,
    output lcs_io_req_t io_req,
    input wire logic [7:0] io_rdata,
    input wire logic io_rd_valid
);
    logic [15:0] base = CFG_BASE_LOW;
    initial io_req = '0;
    task automatic put(input logic [15:0] a, input logic w, input logic r, input logic [7:0] v);
        @(posedge clk_sys);
        io_req <= '{a, w, r, v};
    endtask
    task automatic idle();
        @(posedge clk_sys);
        io_req <= '0;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] v);
        put(base, 1'b1, 1'b0, idx);
        put(base + CFG_DATA_OFS, 1'b1, 1'b0, v);
        idle();
    endtask
    task automatic rd(input logic [7:0] idx, output logic [7:0] v);
        put(base, 1'b1, 1'b0, idx);
        put(base + CFG_DATA_OFS, 1'b0, 1'b1, 8'h00);
        idle();
        #1 v = io_rd_valid ? io_rdata : 8'hxx;
    endtask
    // reserved bits survive because only the wanted bits are or-ed in
    task automatic rmw(input logic [7:0] idx, input logic [7:0] set);
        logic [7:0] v;
        rd(idx, v);
        wr(idx, v | set);
    endtask
    task automatic acc(input logic [15:0] a);
        put(a, 1'b0, 1'b1, 8'h00);
        idle();
        #1;
    endtask
endmodule

// [sim/lcs_config_space_bench.sv]
// self-checking bench for the logical device config space
`timescale 1ns/1ps
module lcs_config_space_bench;
    import lcs_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic lpc_reset = 1'b0;
    logic vsb_por = 1'b0;
    logic config_base_strap = 1'b0;
    lcs_io_req_t io_req;
    logic [7:0] io_rdata;
    logic io_rd_valid;
    logic [NUM_DEV-1:0] dev_active;
    logic [NUM_DEV-1:0] dev_hit;
    logic dev_hit_sel;
    logic [NUM_DEV-1:0][2:0] dma_first;
    logic [NUM_DEV-1:0][2:0] dma_second;
    int n_errors = 0;
    int checks_done = 0;
    int cycles = 0;
    always #5 clk_sys = ~clk_sys;
    lcs_host_model h (.clk_sys(clk_sys), .io_req(io_req), .io_rdata(io_rdata),
        .io_rd_valid(io_rd_valid));
    lcs_config_space i_dut (.clk_sys(clk_sys), .rst(rst), .lpc_reset(lpc_reset),
        .vsb_por(vsb_por), .config_base_strap(config_base_strap), .io_req(io_req),
        .io_rdata(io_rdata), .io_rd_valid(io_rd_valid), .dev_active(dev_active),
        .dev_hit(dev_hit), .dev_hit_offset(), .dev_hit_sel(dev_hit_sel), .dev_irq_num(),
        .dev_irq_level(), .dev_irq_high(), .dev_irq_wake(), .dev_dma_first(dma_first),
        .dev_dma_second(dma_second), .global_config_reg_three(), .pin_select_backup(),
        .pin_lock());
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
        logic [7:0] v;
        h.rd(idx, v);
        chk({8'h00, v}, {8'h00, exp});
    endtask
    task automatic hit_chk(input logic [15:0] a, input logic [NUM_DEV-1:0] exp);
        h.acc(a);
        chk({1'b0, dev_hit}, {1'b0, exp});
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            stop_test();
        end
    end
    initial begin
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1 chk({1'b0, dev_active}, 16'h0060);
        h.wr(IDX_LDN, 8'h00);
        rd_chk(IDX_B0H, 8'h03);
        rd_chk(IDX_B0L, 8'hF0);
        rd_chk(IDX_DMA0, 8'h02);
        h.wr(IDX_LDN, 8'h07);
        rd_chk(IDX_B0L, 8'h00);
        rd_chk(IDX_DMA1, DMA_NONE_READ);
        h.wr(8'h40, 8'h55);
        rd_chk(8'h40, 8'h00);
        h.wr(IDX_VEND_HI, 8'hA5);
        rd_chk(IDX_VEND_HI, 8'hA5);
        $display("test defaults done");
        h.wr(IDX_LDN, 8'h00);
        for (int k = 0; k < 5; k++) begin
            h.wr(IDX_DMA0, 8'(k));
            rd_chk(IDX_DMA0, 8'(k));
        end
        h.wr(IDX_LDN, 8'h02);
        h.wr(IDX_DMA1, 8'h03);
        rd_chk(IDX_DMA1, 8'h03);
        $display("test dma done");
        h.wr(IDX_LDN, 8'h00);
        h.rmw(IDX_ACT, 8'h01);
        hit_chk(16'h03F5, 15'h0001);
        hit_chk(16'h13F5, 15'h0000);
        hit_chk(16'h03F8, 15'h0000);
        h.wr(IDX_ACT, 8'h00);
        hit_chk(16'h03F5, 15'h0000);
        hit_chk(16'h0064, 15'h0040);
        chk({15'h0000, dev_hit_sel}, 16'h0001);
        $display("test decode done");
        h.wr(IDX_B0H, 8'hFF);
        h.wr(IDX_B0L, 8'hFF);
        rd_chk(IDX_B0H, 8'h07);
        rd_chk(IDX_B0L, 8'hF8);
        h.wr(IDX_LDN, 8'h0D);
        h.wr(IDX_B0H, 8'hFF);
        h.wr(IDX_B0L, 8'hFF);
        rd_chk(IDX_B0H, 8'hFF);
        rd_chk(IDX_B0L, 8'hE0);
        h.wr(IDX_LDN, 8'h01);
        h.wr(IDX_B0H, 8'h04);
        rd_chk(IDX_B0H, 8'h03);
        $display("test base filter done");
        h.wr(IDX_GCR1, 8'h02);
        repeat (3) @(posedge clk_sys);
        h.wr(IDX_LDN, 8'h00);
        rd_chk(IDX_B0H, 8'h03);
        rd_chk(IDX_DMA0, 8'h02);
        h.wr(IDX_LDN, 8'h01);
        h.wr(IDX_ACT, 8'h01);
        hit_chk(16'h077A, 15'h0002);
        chk({15'h0000, dev_hit_sel}, 16'h0001);
        $display("test soft reset done");
        @(posedge clk_sys);
        config_base_strap <= 1'b1;
        lpc_reset <= 1'b1;
        repeat (2) @(posedge clk_sys);
        lpc_reset <= 1'b0;
        h.base = CFG_BASE_HIGH;
        #1 chk({1'b0, dev_active}, 16'h0060);
        h.wr(IDX_LDN, 8'h04);
        h.wr(IDX_VEND_LO, 8'h5A);
        rd_chk(IDX_VEND_LO, 8'h5A);
        @(posedge clk_sys);
        vsb_por <= 1'b1;
        @(posedge clk_sys);
        vsb_por <= 1'b0;
        rd_chk(IDX_VEND_LO, 8'h00);
        $display("test hardware reset done");
        stop_test();
    end
endmodule
